// ===== core/dpr_port_master.sv
// Port master that drives one side of the asynchronous dual-port memory
`timescale 1ns/1ps
module dpr_port_master
  import dpr_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  // User request side
  input  wire logic              req,
  input  wire logic              req_wr,
  input  wire logic              req_sem,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  output logic                   ready_r,
  output logic                   done_r,
  output logic [DATA_W-1:0]      rdata_r,
  output logic                   busy_hit_r,
  output logic                   mbox_r,
  // Role configuration
  input  wire logic              role_master,
  input  wire logic              ext_busy_n,
  // Device port pins
  output logic                   select_low_active_n_r,
  output logic                   select_high_active_r,
  output logic                   token_latch_select_n_r,
  output logic                   rd_wr_n_r,
  output logic                   out_en_n_r,
  output logic [ADDR_W-1:0]      addr_r,
  output logic [DATA_W-1:0]      data_o_r,
  output logic                   data_oe_r,
  input  wire logic [DATA_W-1:0] data_i,
  output logic                   role_master_r,
  input  wire logic              busy_n_i,
  output logic                   busy_n_o_r,
  output logic                   busy_oe_r,
  input  wire logic              int_n_i
);

  dpr_state_t state_r;
  dpr_state_t state_nxt;
  logic       wr_r;
  logic       sem_r;
  logic       stall;

  dpr_cnt_if cnt ();

  dpr_wait_cnt u_wait (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .cnt     (cnt.tmr)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  // Busy only counts when this device arbitrates; a slave never flags
  assign stall = role_master_r && !busy_n_i;

  always_comb begin
    state_nxt = state_r;
    cnt.load  = 1'b0;
    cnt.val   = ACC_CYC;
    unique case (state_r)
      DPR_IDLE: begin
        if (req) begin
          state_nxt = DPR_SETUP;
        end
      end
      DPR_SETUP: begin
        state_nxt = DPR_ACCESS;
        cnt.load  = 1'b1;
      end
      DPR_ACCESS: begin
        if (cnt.done && !stall) begin
          state_nxt = DPR_RECOV;
          cnt.load  = 1'b1;
          cnt.val   = REC_CYC;
        end else if (cnt.done) begin
          // Keep the access open and re-time it until the other side lets go
          cnt.load  = 1'b1;
        end
      end
      DPR_RECOV: begin
        if (cnt.done) begin
          state_nxt = DPR_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r <= DPR_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************
  // Request capture
  // ****************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_r      <= 1'b0;
      sem_r     <= 1'b0;
      addr_r    <= ADDR_RST;
      data_o_r  <= DATA_RST;
      rd_wr_n_r <= 1'b1;
    end else if (state_r == DPR_IDLE && req) begin
      wr_r      <= req_wr;
      sem_r     <= req_sem;
      addr_r    <= req_addr;
      data_o_r  <= req_wdata;
      rd_wr_n_r <= !req_wr;
    end
  end

  // ****************************************
  // Select and enable pins
  // ****************************************
  // Address settles one cycle before any select; selects drop before
  // the address may move, so the port powers down between accesses
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      select_low_active_n_r  <= 1'b1;
      select_high_active_r   <= 1'b0;
      token_latch_select_n_r <= 1'b1;
      out_en_n_r             <= 1'b1;
    end else if (state_nxt == DPR_ACCESS) begin
      select_low_active_n_r  <= sem_r;
      select_high_active_r   <= !sem_r;
      token_latch_select_n_r <= !sem_r;
      out_en_n_r             <= wr_r;
    end else begin
      select_low_active_n_r  <= 1'b1;
      select_high_active_r   <= 1'b0;
      token_latch_select_n_r <= 1'b1;
      out_en_n_r             <= 1'b1;
    end
  end

  // Drive data only while the device outputs are off
  // On accept wr_r still holds the last access, so use the request itself
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      data_oe_r <= 1'b0;
    end else if (state_r == DPR_IDLE) begin
      data_oe_r <= req && req_wr;
    end else begin
      data_oe_r <= wr_r && (state_nxt == DPR_ACCESS);
    end
  end

  // ****************************************
  // User answers
  // ****************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      done_r  <= 1'b0;
      rdata_r <= DATA_RST;
    end else begin
      done_r <= (state_r == DPR_ACCESS) && (state_nxt == DPR_RECOV);
      if (state_r == DPR_ACCESS && state_nxt == DPR_RECOV && !wr_r) begin
        rdata_r <= data_i;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= (state_nxt == DPR_IDLE);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busy_hit_r <= 1'b0;
    end else if (state_r == DPR_IDLE && req) begin
      busy_hit_r <= 1'b0;
    end else if (state_r == DPR_ACCESS && stall) begin
      busy_hit_r <= 1'b1;
    end
  end

  // Mailbox flag from the device, active low at the pin
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mbox_r <= 1'b0;
    end else begin
      mbox_r <= !int_n_i;
    end
  end

  // ****************************************
  // Role and busy direction
  // ****************************************
  // A slave takes busy from the master device, so the host feeds it in
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      role_master_r <= 1'b1;
      busy_oe_r     <= 1'b0;
      busy_n_o_r    <= 1'b1;
    end else begin
      role_master_r <= role_master;
      busy_oe_r     <= !role_master;
      busy_n_o_r    <= ext_busy_n;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_sel_pair;
    @(posedge clk_sys) disable iff (!rstn)
    select_low_active_n_r == !select_high_active_r;
  endproperty
  a_sel_pair: assert property (p_sel_pair) else $error("Chip selects disagree");

  property p_sel_excl;
    @(posedge clk_sys) disable iff (!rstn)
    !(!select_low_active_n_r && !token_latch_select_n_r);
  endproperty
  a_sel_excl: assert property (p_sel_excl) else $error("Memory and token selected together");

  property p_no_contend;
    @(posedge clk_sys) disable iff (!rstn)
    data_oe_r |-> out_en_n_r && !rd_wr_n_r;
  endproperty
  a_no_contend: assert property (p_no_contend) else $error("Data driven while device may drive");

  property p_idle_down;
    @(posedge clk_sys) disable iff (!rstn)
    (state_r == DPR_IDLE && !req) |=> select_low_active_n_r && token_latch_select_n_r;
  endproperty
  a_idle_down: assert property (p_idle_down) else $error("Port selected while idle");

  property p_busy_dir;
    @(posedge clk_sys) disable iff (!rstn)
    ##1 busy_oe_r == !$past(role_master);
  endproperty
  a_busy_dir: assert property (p_busy_dir) else $error("Busy direction does not follow role");

  property p_token_write;
    @(posedge clk_sys) disable iff (!rstn)
    $fell(token_latch_select_n_r) && !rd_wr_n_r |-> data_oe_r [*1] ##1 (data_oe_r || token_latch_select_n_r);
  endproperty
  a_token_write: assert property (p_token_write) else $error("Token write without data");

endmodule

// ===== core/dpr_pkg.sv
// Shared constants and types for the dual-port memory port master
package dpr_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int ADDR_W = 17;
  localparam int DATA_W = 9;
  localparam int CNT_W  = 4;

  // ****************************************
  // Timing, slowest speed grade
  // ****************************************
  localparam int CLK_NS    = 25;
  localparam int T_AA_NS   = 25;
  localparam int T_HZ_NS   = 15;
  localparam int ACC_CYC_I = (T_AA_NS + CLK_NS - 1) / CLK_NS;
  localparam int REC_CYC_I = (T_HZ_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [CNT_W-1:0] ACC_CYC = CNT_W'(ACC_CYC_I < 1 ? 1 : ACC_CYC_I);
  localparam logic [CNT_W-1:0] REC_CYC = CNT_W'(REC_CYC_I < 1 ? 1 : REC_CYC_I);
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;
  localparam logic [DATA_W-1:0] DATA_RST = 9'h000;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    DPR_IDLE,
    DPR_SETUP,
    DPR_ACCESS,
    DPR_RECOV
  } dpr_state_t;

endpackage

// ===== core/dpr_cnt_if.sv
// Load and expiry handshake between sequencer and wait counter
`timescale 1ns/1ps
interface dpr_cnt_if;
  import dpr_pkg::*;
  logic             load;
  logic [CNT_W-1:0] val;
  logic             done;
  modport ctl (output load, output val, input done);
  modport tmr (input load, input val, output done);
endinterface

// ===== core/dpr_wait_cnt.sv
// Down counter that marks the end of a pin timing interval
`timescale 1ns/1ps
module dpr_wait_cnt
  import dpr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Sequencer side
  dpr_cnt_if.tmr   cnt
);

  logic [CNT_W-1:0] cnt_r;

  // ****************************************
  // Counter
  // ****************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= CNT_ZERO;
    end else if (cnt.load) begin
      cnt_r <= cnt.val;
    end else if (cnt_r != CNT_ZERO) begin
      cnt_r <= cnt_r - CNT_ONE;
    end
  end

  // Expires on the last counted cycle, so a load of N spans N edges
  // No term from load here: load itself follows done, which would close a loop
  assign cnt.done = (cnt_r == CNT_ONE);

endmodule

// ===== testbench/dpr_dev_model.sv
// Behavioural model of the dual-port memory device as seen from one port
`timescale 1ns/1ps
module dpr_dev_model
  import dpr_pkg::*;
(
  // Host pins
  input  wire logic              role_master,
  input  wire logic              sel_low_n,
  input  wire logic              sel_high,
  input  wire logic              tok_n,
  input  wire logic              rd_wr_n,
  input  wire logic              oe_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] host_d,
  input  wire logic              host_oe,
  input  wire logic              host_busy_n,
  input  wire logic              host_busy_oe,
  output logic      [DATA_W-1:0] dq,
  output logic                   busy_n,
  output logic                   int_n,
  // Stand-in for the far port
  input  wire logic              oth_act,
  input  wire logic [ADDR_W-1:0] oth_addr,
  input  wire logic [7:0]        oth_sem,
  input  wire logic              int_set
);
  // ****************************************
  // Storage and decode
  // ****************************************
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [7:0]        own;
  logic [DATA_W-1:0] rd;
  logic [DATA_W-1:0] last_q;
  logic              ce;
  logic              token_latch_select;
  logic              drv;

  initial begin
    own = '0;
    last_q = '0;
  end

  assign ce  = !sel_low_n && sel_high;
  assign token_latch_select = !tok_n && !ce;
  assign rd  = token_latch_select ? {DATA_W{~own[addr[2:0]]}} : mem[addr];
  assign drv = (ce || token_latch_select) && rd_wr_n && !oe_n;

  // ****************************************
  // Data pins
  // ****************************************
  always @* if (drv) last_q = rd;
  // No pull on the bus, so a released bus must not keep the last value
  assign dq = host_oe ? host_d : (drv ? rd : ~last_q);
  always @* if (ce && !rd_wr_n && host_oe) mem[addr] = host_d;
  always @* if (token_latch_select && !rd_wr_n && host_oe) own[addr[2:0]] = !host_d[0] && !oth_sem[addr[2:0]];

  // ****************************************
  // Flags
  // ****************************************
  // Slave parts take busy from outside; pull-up when nobody drives
  assign busy_n = role_master ? !(oth_act && ce && addr == oth_addr)
                              : (host_busy_oe ? host_busy_n : 1'b1);
  assign int_n  = !int_set;
endmodule

// ===== testbench/dpr_port_master_tb.sv
// Self-checking bench for the dual-port memory port master
`timescale 1ns/1ps
module dpr_port_master_tb;
  import dpr_pkg::*;
  logic clk_sys = 0, rstn = 0, req = 0, req_wr = 0, req_sem = 0, role_master = 1, ext_busy_n = 1;
  logic oth_act = 0, int_set = 0;
  logic [7:0]        oth_sem = '0;
  logic [ADDR_W-1:0] req_addr = '0, oth_addr = '0, addr_r, a;
  logic [DATA_W-1:0] req_wdata = '0, dq, rdata_r, data_o_r, got, d;
  logic ready_r, done_r, busy_hit_r, mbox_r, sl_n, sh, tk_n, rw_n, oe_n, d_oe, role_r, bsy_n, bsy_o, bsy_oe, int_n;
  logic [31:0]       lfsr = 32'hee36;
  logic [DATA_W-1:0] ref_m [logic [ADDR_W-1:0]];
  int                error_cnt = 0, n_checks = 0;

  initial forever #12.5 clk_sys = ~clk_sys;

  dpr_port_master dut_u (.clk_sys(clk_sys), .rstn(rstn), .req(req), .req_wr(req_wr), .req_sem(req_sem),
    .req_addr(req_addr), .req_wdata(req_wdata), .ready_r(ready_r), .done_r(done_r), .rdata_r(rdata_r),
    .busy_hit_r(busy_hit_r), .mbox_r(mbox_r), .role_master(role_master), .ext_busy_n(ext_busy_n),
    .select_low_active_n_r(sl_n), .select_high_active_r(sh), .token_latch_select_n_r(tk_n),
    .rd_wr_n_r(rw_n), .out_en_n_r(oe_n), .addr_r(addr_r), .data_o_r(data_o_r), .data_oe_r(d_oe),
    .data_i(dq), .role_master_r(role_r), .busy_n_i(bsy_n), .busy_n_o_r(bsy_o), .busy_oe_r(bsy_oe),
    .int_n_i(int_n));

  dpr_dev_model dev_u (.role_master(role_r), .sel_low_n(sl_n), .sel_high(sh), .tok_n(tk_n), .rd_wr_n(rw_n),
    .oe_n(oe_n), .addr(addr_r), .host_d(data_o_r), .host_oe(d_oe), .host_busy_n(bsy_o),
    .host_busy_oe(bsy_oe), .dq(dq), .busy_n(bsy_n), .int_n(int_n), .oth_act(oth_act),
    .oth_addr(oth_addr), .oth_sem(oth_sem), .int_set(int_set));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Bounded waits so a stuck sequencer ends as a mismatch
  task automatic access(input logic wr, input logic sm, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] wd);
    int n;
    n = 0;
    while (ready_r !== 1'b1 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    check("ready", ready_r, 1);
    req = 1'b1;
    req_wr = wr;
    req_sem = sm;
    req_addr = ad;
    req_wdata = wd;
    @(negedge clk_sys);
    req = 1'b0;
    n = 0;
    while (done_r !== 1'b1 && n < 50) begin
      @(negedge clk_sys);
      if (sl_n === 1'b0 || tk_n === 1'b0) check("sel", {sl_n, sh, tk_n}, sm ? 3'b100 : 3'b011);
      n++;
    end
    if (n >= 50) check("done", 0, 1);
    got = rdata_r;
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    check("rst_pins", {sl_n, sh, tk_n, oe_n, d_oe}, 5'b10110);
    rstn = 1'b1;
    for (int i = 0; i < 24; i++) begin
      lfsr = lfsr_next(lfsr);
      a = (i < 2) ? {ADDR_W{i[0]}} : lfsr[ADDR_W-1:0];
      d = lfsr[25:17];
      access(1'b1, 1'b0, a, d);
      ref_m[a] = d;
    end
    foreach (ref_m[k]) begin
      access(1'b0, 1'b0, k, '0);
      check("rdata", got, ref_m[k]);
      check("busy_clr", busy_hit_r, 0);
    end
    oth_sem = 8'h20;
    for (int s = 0; s < 8; s++) begin
      access(1'b1, 1'b1, ADDR_W'(s), '0);
      access(1'b0, 1'b1, ADDR_W'(s), '0);
      check("sem", got[0], 32'(s == 5));
    end
    oth_act = 1'b1;
    fork
      access(1'b0, 1'b0, '0, '0);
      begin
        repeat (6) @(negedge clk_sys);
        oth_act = 1'b0;
      end
    join
    check("busy_hit", busy_hit_r, 1);
    check("busy_data", got, ref_m[17'h00000]);
    role_master = 1'b0;
    ext_busy_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    check("slave", {role_r, bsy_oe, bsy_o, bsy_n}, 4'b0100);
    role_master = 1'b1;
    ext_busy_n = 1'b1;
    int_set = 1'b1;
    repeat (3) @(negedge clk_sys);
    check("mbox", mbox_r, 1);
    int_set = 1'b0;
    repeat (3) @(negedge clk_sys);
    check("mbox", mbox_r, 0);
    give_verdict();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #(25 * 5000);
    error_cnt++;
    give_verdict();
  end
endmodule
